// ---- fkb_boot_port.sv ----
// Fuse key boot command port: serial slave, unlock, fuse commands
`include "fkb_params.svh"
module fkb_boot_port import fkb_pkg::*; #(
  parameter logic [31:0] HW_SIG = 32'h0000_5a5a // Arbitrary value
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic serial_shift_clock_i,
  input wire logic slave_select_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic blowing_o
);
  logic sck_s, sel_s, ss_n_s, mosi_s, sck_q, ss_q;
  logic sck_rise, sck_fall, frame_start, frame_end, exec;
  logic [7:0] bit_cnt, pay_bits;
  logic [47:0] hdr;
  logic [127:0] pay, staging, tx_sh;
  logic [127:0] shadow [3];
  logic [79:0] reply;
  logic reply_vld;
  logic [15:0] cmd;
  fkb_unlock_t unlock_st;
  fkb_box_t last_box, eng_box;
  fkb_eng_t eng_st;
  logic [1:0] idx;
  logic [15:0] tmr;
  logic mem_wr, mem_rd;
  logic [31:0] mem_rdata, ctrl_eff;
  logic [4:0] word_len, word_bits;
  logic [7:0] words_rx, frames;
  logic refused, refuse_ev, ack;
  logic start_blow, start_read;
  fkb_box_t next_box;

  // Box addressed by a copy or read command
  function automatic fkb_box_t box_of(input logic [15:0] c);
    unique case (c)
      `FKB_CMD_TO_AUTH, `FKB_CMD_RD_AUTH: box_of = box_auth;
      `FKB_CMD_TO_CTRL, `FKB_CMD_RD_CTRL: box_of = box_ctrl;
      default: box_of = box_enc;
    endcase
  endfunction : box_of

  // Word of a box value, word 0 being the most significant
  function automatic logic [31:0] word_of(input logic [127:0] v,
                                          input logic [1:0] i);
    unique case (i)
      2'h0: word_of = v[127:96];
      2'h1: word_of = v[95:64];
      2'h2: word_of = v[63:32];
      default: word_of = v[31:0];
    endcase
  endfunction : word_of

  // Write lock from the effective control bits
  function automatic logic wr_locked(input fkb_box_t b,
                                     input logic [31:0] c);
    wr_locked = (b == box_ctrl) ? c[`FKB_CTL_WR_CTRL] : c[`FKB_CTL_WR_KEY];
  endfunction : wr_locked

  // Pins cross from the master's clock into the core domain
  fkb_sync #(.W(3)) u_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .d_i({serial_shift_clock_i, !slave_select_n_i, mosi_i}),
    .q_o({sck_s, sel_s, mosi_s})
  );

  // Chain resets to zero, so select crosses inverted and reads idle
  assign ss_n_s = !sel_s;

  // Edge history of the synchronised pins
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sck_q <= 1'b0;
      ss_q <= 1'b1;
    end else begin
      sck_q <= sck_s;
      ss_q <= ss_n_s;
    end
  end

  // Edges count only while selected; one pulse moves one bit
  assign sck_rise = sck_s && !sck_q && !ss_n_s;
  assign sck_fall = !sck_s && sck_q && !ss_n_s;
  assign frame_start = !ss_n_s && ss_q;
  assign frame_end = ss_n_s && !ss_q;
  assign exec = frame_end && bit_cnt >= 8'(`FKB_HDR_BITS);
  assign cmd = hdr[15:0];

  // Header then payload, captured MSB first on rising clock edges
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bit_cnt <= 8'h0;
      pay_bits <= 8'h0;
      hdr <= 48'h0;
      pay <= 128'h0;
    end else if (frame_start) begin
      bit_cnt <= 8'h0;
      pay_bits <= 8'h0;
      pay <= 128'h0;
    end else if (sck_rise) begin
      if (bit_cnt < 8'(`FKB_HDR_BITS)) begin
        hdr <= {hdr[46:0], mosi_s};
        bit_cnt <= bit_cnt + 8'h1;
      end else if (pay_bits < 8'(`FKB_KEY_BITS)) begin
        pay <= {pay[126:0], mosi_s};
        pay_bits <= pay_bits + 8'h1;
      end
    end
  end

  // Word framing follows the configured 8 to 16 bit length
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      word_bits <= 5'h0;
      words_rx <= 8'h0;
    end else if (frame_start) begin
      word_bits <= 5'h0;
    end else if (sck_rise) begin
      if (word_bits == word_len - 5'h1) begin
        word_bits <= 5'h0;
        words_rx <= words_rx + 8'h1;
      end else begin
        word_bits <= word_bits + 5'h1;
      end
    end
  end

  // Output shifter: reply of the last status poll, or a shadow dump
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_sh <= 128'h0;
    end else if (frame_start) begin
      tx_sh <= reply_vld ? {reply, 48'h0} : 128'h0;
    end else if (sck_fall) begin
      if (bit_cnt == 8'(`FKB_HDR_BITS) && pay_bits == 8'h0 &&
          cmd == `FKB_CMD_DUMP && unlock_st == ul_open &&
          !(last_box == box_ctrl ? ctrl_eff[`FKB_CTL_RD_CTRL] :
          ctrl_eff[`FKB_CTL_RD_KEY])) begin
        tx_sh <= shadow[last_box];
      end else begin
        tx_sh <= {tx_sh[126:0], 1'b0};
      end
    end
  end

  // Line driven only while selected; the master arbitrates slaves
  assign miso_o = tx_sh[127];
  assign miso_oe_o = !ss_n_s;

  // Unlock sequence, restarted by any wrong frame that carries a full header
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      unlock_st <= ul_wait_a;
    end else if (exec && unlock_st != ul_open) begin
      if (cmd == `FKB_CMD_UNLOCK && pay[31:0] == `FKB_UNLOCK_B &&
          unlock_st == ul_wait_b) begin
        unlock_st <= ul_open;
      end else if (cmd == `FKB_CMD_UNLOCK && pay[31:0] == `FKB_UNLOCK_A) begin
        unlock_st <= ul_wait_b;
      end else begin
        unlock_st <= ul_wait_a;
      end
    end
  end

  // Command decode at frame end; engine busy refuses all but status and dump
  always_comb begin
    start_blow = 1'b0;
    start_read = 1'b0;
    refuse_ev = 1'b0;
    next_box = box_of(cmd);
    if (exec && unlock_st == ul_open) begin
      unique case (cmd)
        `FKB_CMD_STATUS, `FKB_CMD_DUMP: refuse_ev = 1'b0;
        `FKB_CMD_STAGE, `FKB_CMD_TO_ENC, `FKB_CMD_TO_AUTH,
        `FKB_CMD_TO_CTRL: refuse_ev = (eng_st != eng_idle) ||
          (cmd != `FKB_CMD_STAGE && wr_locked(next_box, ctrl_eff));
        `FKB_CMD_BLOW: begin
          next_box = last_box;
          refuse_ev = (eng_st != eng_idle) || wr_locked(last_box, ctrl_eff);
          start_blow = !refuse_ev;
        end
        `FKB_CMD_RD_ENC, `FKB_CMD_RD_AUTH: begin
          refuse_ev = (eng_st != eng_idle) || ctrl_eff[`FKB_CTL_RD_KEY];
          start_read = !refuse_ev;
        end
        `FKB_CMD_RD_CTRL: begin
          refuse_ev = eng_st != eng_idle;
          start_read = !refuse_ev;
        end
        default: refuse_ev = 1'b1;
      endcase
    end else if (exec) begin
      refuse_ev = cmd != `FKB_CMD_UNLOCK;
    end
  end

  // Staging buffer and shadow registers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      staging <= 128'h0;
      last_box <= box_enc;
      for (int i = 0; i < 3; i++) begin
        shadow[i] <= 128'h0;
      end
    end else if (eng_st == eng_wait) begin
      unique case (idx)
        2'h0: shadow[eng_box][127:96] <= mem_rdata;
        2'h1: shadow[eng_box][95:64] <= mem_rdata;
        2'h2: shadow[eng_box][63:32] <= mem_rdata;
        default: shadow[eng_box][31:0] <= mem_rdata;
      endcase
    end else if (exec && unlock_st == ul_open && !refuse_ev) begin
      if (cmd == `FKB_CMD_STAGE) begin
        staging <= pay;
      end else if (cmd == `FKB_CMD_TO_ENC || cmd == `FKB_CMD_TO_AUTH ||
                   cmd == `FKB_CMD_TO_CTRL) begin
        shadow[next_box] <= staging;
        last_box <= next_box;
      end else if (start_read) begin
        last_box <= next_box;
      end
    end
  end

  // Blow and read engine; one word per step, blow waits its time
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      eng_st <= eng_idle;
      eng_box <= box_enc;
      idx <= 2'h0;
      tmr <= 16'h0;
    end else begin
      unique case (eng_st)
        eng_idle: begin
          idx <= 2'h0;
          tmr <= 16'h0;
          eng_box <= next_box;
          if (start_blow) begin
            eng_st <= eng_blow;
          end else if (start_read) begin
            eng_st <= eng_read;
          end
        end
        eng_blow: begin
          if (tmr == 16'(`FKB_BLOW_CYC - 1)) begin
            tmr <= 16'h0;
            idx <= idx + 2'h1;
            if (idx == 2'h3) begin
              eng_st <= eng_idle;
            end
          end else begin
            tmr <= tmr + 16'h1;
          end
        end
        eng_read: eng_st <= eng_wait;
        eng_wait: begin
          idx <= idx + 2'h1;
          eng_st <= (idx == 2'h3) ? eng_idle : eng_read;
        end
      endcase
    end
  end

  assign mem_wr = eng_st == eng_blow && tmr == 16'h0;
  assign mem_rd = eng_st == eng_read;
  assign blowing_o = eng_st == eng_blow;

  fkb_fuse_mem u_mem (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .wr_en_i(mem_wr),
    .wr_addr_i({eng_box, idx}),
    .wr_data_i(word_of(shadow[eng_box], idx)),
    .rd_en_i(mem_rd),
    .rd_addr_i({eng_box, idx}),
    .rd_data_o(mem_rdata)
  );

  // Control bits take effect only after a control box read-back
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_eff <= 32'h0;
    end else if (eng_st == eng_wait && eng_box == box_ctrl &&
                 idx == 2'h3) begin
      ctrl_eff <= mem_rdata;
    end
  end

  // Status reply, shifted out in the next frame
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reply <= 80'h0;
      reply_vld <= 1'b0;
    end else if (exec && unlock_st == ul_open && cmd == `FKB_CMD_STATUS) begin
      reply <= {HW_SIG, 16'h0000, (eng_st == eng_blow) ?
                `FKB_STAT_BLOWING : `FKB_STAT_READY};
      reply_vld <= 1'b1;
    end else if (frame_start) begin
      reply_vld <= 1'b0;
    end
  end

  // Avalon slave: one wait state, then the answer
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack <= 1'b0;
      avs_readdata_o <= 32'h0;
    end else begin
      ack <= (avs_read_i || avs_write_i) && !ack;
      if (avs_read_i && !ack) begin
        unique case (avs_address_i)
          `FKB_REG_CTRL: avs_readdata_o <= {27'h0, word_len};
          `FKB_REG_STATUS: avs_readdata_o <= {frames, words_rx, 11'h0,
            blowing_o, refused, eng_st != eng_idle, unlock_st};
          `FKB_REG_SIG: avs_readdata_o <= HW_SIG;
          `FKB_REG_FUSECTL: avs_readdata_o <= ctrl_eff;
          default: avs_readdata_o <= 32'h0;
        endcase
      end
    end
  end

  // Word length register, clamped to the supported range
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      word_len <= `FKB_WLEN_RST;
    end else if (avs_write_i && ack && avs_byteenable_i[0] &&
                 avs_address_i == `FKB_REG_CTRL) begin
      // Whole word compared, so a large value clamps instead of wrapping
      word_len <= (avs_writedata_i < 32'(`FKB_WLEN_MIN)) ? `FKB_WLEN_MIN :
        (avs_writedata_i > 32'(`FKB_WLEN_MAX)) ? `FKB_WLEN_MAX :
        avs_writedata_i[4:0];
    end
  end

  // Sticky refusal flag, write one to clear; a new refusal wins
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      refused <= 1'b0;
      frames <= 8'h0;
    end else begin
      if (refuse_ev) begin
        refused <= 1'b1;
      end else if (avs_write_i && ack && avs_byteenable_i[0] &&
                   avs_address_i == `FKB_REG_STATUS &&
                   avs_writedata_i[`FKB_STS_REFUSED]) begin
        refused <= 1'b0;
      end
      if (frame_end) begin
        frames <= frames + 8'h1;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  AST_LOCKED_HOLD: assert property (
    exec && unlock_st != ul_open |=> $stable(staging) && eng_st == eng_idle)
    else $error("locked port acted on a command");
  AST_STAGE_LOAD: assert property (
    exec && unlock_st == ul_open && cmd == `FKB_CMD_STAGE && !refuse_ev
    |=> staging == $past(pay)) else $error("staging not loaded");
  AST_COPY_ENC: assert property (
    exec && unlock_st == ul_open && cmd == `FKB_CMD_TO_ENC && !refuse_ev
    |=> shadow[box_enc] == $past(staging) && last_box == box_enc)
    else $error("encryption shadow not copied");
  AST_BLOW_START: assert property (
    start_blow |=> blowing_o && mem_wr && eng_box == $past(last_box))
    else $error("blow did not start on the last box");
  AST_STATUS_REPLY: assert property (
    exec && unlock_st == ul_open && cmd == `FKB_CMD_STATUS
    |=> reply_vld && reply[79:48] == HW_SIG && reply[47:32] == 16'h0 &&
        reply[0] == $past(blowing_o)) else $error("bad status reply");
  AST_DESELECT_QUIET: assert property (
    ss_n_s && $past(ss_n_s) |-> $stable(hdr) && $stable(pay) && !miso_oe_o)
    else $error("activity while deselected");
  AST_KEY_READ_LOCK: assert property (
    exec && unlock_st == ul_open && cmd == `FKB_CMD_RD_ENC &&
    eng_st == eng_idle &&
    ctrl_eff[`FKB_CTL_RD_KEY] |=> eng_st == eng_idle && refused)
    else $error("key read not refused");
  AST_CTRL_WRITE_LOCK: assert property (
    exec && unlock_st == ul_open && cmd == `FKB_CMD_BLOW &&
    eng_st == eng_idle &&
    last_box == box_ctrl && ctrl_eff[`FKB_CTL_WR_CTRL] |=> !blowing_o)
    else $error("control blow not refused");
  AST_HDR_SHIFT: assert property (
    sck_rise && bit_cnt < 8'(`FKB_HDR_BITS) |=> hdr[0] == $past(mosi_s))
    else $error("header bit not captured");
  AST_READ_STEPS: assert property (
    start_read |=> eng_st == eng_read ##1 eng_st == eng_wait ##1
    eng_st == eng_read ##1 eng_st == eng_wait)
    else $error("read engine out of step");

  COV_UNLOCK: cover property (unlock_st == ul_wait_b ##1
    unlock_st == ul_open);
  COV_BLOW_DONE: cover property (blowing_o ##1 !blowing_o);
  COV_DUMP: cover property (sck_fall && cmd == `FKB_CMD_DUMP &&
    bit_cnt == 8'(`FKB_HDR_BITS) && unlock_st == ul_open);
endmodule : fkb_boot_port

// ---- fkb_fuse_mem.sv ----
// Fuse array of three boxes, four words each, registered read
module fkb_fuse_mem (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic wr_en_i,
  input wire logic [3:0] wr_addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic rd_en_i,
  input wire logic [3:0] rd_addr_i,
  output logic [31:0] rd_data_o
);
  logic [31:0] fuse [12];

  // Blowing only sets bits; a blown fuse returns to zero only on reset
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < 12; i++) begin
        fuse[i] <= 32'h0;
      end
    end else if (wr_en_i && wr_addr_i < 4'hc) begin
      fuse[wr_addr_i] <= fuse[wr_addr_i] | wr_data_i;
    end
  end

  // Read data from a register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_data_o <= 32'h0;
    end else if (rd_en_i) begin
      rd_data_o <= (rd_addr_i < 4'hc) ? fuse[rd_addr_i] : 32'h0;
    end
  end
endmodule : fkb_fuse_mem

// ---- fkb_host_model.sv ----
// Serial master model standing in for the host controller
module fkb_host_model (
  output logic sclk_o,
  output logic ss_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle: clock low, slave deselected
  initial begin
    sclk_o = 1'b0;
    ss_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // One frame in mode 0, MSB first, 200 ns bit period
  task automatic frame(input logic [31:0] a, input logic [15:0] c,
    input logic [127:0] d, input int dbits, output logic [175:0] rx);
    logic [175:0] v;
    v = {a, c, d};
    rx = '0;
    ss_n_o <= 1'b0; // Only this slave is selected
    #200;
    for (int i = 0; i < 48 + dbits; i++) begin
      mosi_o <= v[175 - i];
      #100 sclk_o <= 1'b1; // One pulse per bit
      rx = {rx[174:0], miso_i};
      #100 sclk_o <= 1'b0;
    end
    #100 ss_n_o <= 1'b1;
    mosi_o <= ~mosi_o; // Released data line must not look valid
    #400;
  endtask : frame
endmodule : fkb_host_model

// ---- fkb_params.svh ----
// Constants for the fuse key boot command port
`ifndef FKB_PARAMS_SVH
`define FKB_PARAMS_SVH
`define FKB_CLK_MHZ 40
`define FKB_BLOW_TIME_NS 10000
`define FKB_BLOW_CYC ((`FKB_BLOW_TIME_NS * `FKB_CLK_MHZ + 999) / 1000)
`define FKB_ADDR_BITS 32
`define FKB_HDR_BITS 48
`define FKB_KEY_BITS 128
`define FKB_BOX_WORDS 4
`define FKB_CMD_UNLOCK 16'hde05
`define FKB_UNLOCK_A 32'h5345acba
`define FKB_UNLOCK_B 32'hacba5345
`define FKB_CMD_STAGE 16'h0007
`define FKB_CMD_TO_ENC 16'h0008
`define FKB_CMD_TO_AUTH 16'h0009
`define FKB_CMD_TO_CTRL 16'h000b
`define FKB_CMD_BLOW 16'h000c
`define FKB_CMD_RD_ENC 16'h000d
`define FKB_CMD_RD_AUTH 16'h000e
`define FKB_CMD_RD_CTRL 16'h0010
`define FKB_CMD_DUMP 16'h0011
`define FKB_CMD_STATUS 16'h0012
`define FKB_STAT_BLOWING 32'h00000001
`define FKB_STAT_READY 32'h00000000
`define FKB_CTL_RD_KEY 1
`define FKB_CTL_WR_KEY 2
`define FKB_CTL_RD_CTRL 5
`define FKB_CTL_WR_CTRL 6
`define FKB_REG_CTRL 4'h0
`define FKB_REG_STATUS 4'h4
`define FKB_REG_SIG 4'h8
`define FKB_REG_FUSECTL 4'hc
`define FKB_WLEN_RST 5'h10
`define FKB_WLEN_MIN 5'h08
`define FKB_WLEN_MAX 5'h10
`define FKB_STS_REFUSED 3
`endif

// ---- fkb_pkg.sv ----
// Types shared by the fuse key boot command port
package fkb_pkg;
  typedef enum logic [1:0] {ul_wait_a, ul_wait_b, ul_open} fkb_unlock_t;
  typedef enum logic [1:0] {box_enc, box_auth, box_ctrl} fkb_box_t;
  typedef enum logic [1:0] {eng_idle, eng_blow, eng_read, eng_wait}
    fkb_eng_t;
endpackage : fkb_pkg

// ---- fkb_sync.sv ----
// Two flip-flop synchroniser, one chain per bit
module fkb_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  // First stage feeds only the second stage
  for (genvar g = 0; g < W; g++) begin : g_bit
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        meta[g] <= 1'b0;
        q_o[g] <= 1'b0;
      end else begin
        meta[g] <= d_i[g];
        q_o[g] <= meta[g];
      end
    end
  end
endmodule : fkb_sync

// ---- tb_fkb_boot_port.sv ----
// Self-checking testbench for the fuse key boot command port
module tb_fkb_boot_port;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] SIG = 32'h0000_3c3c; // Arbitrary value
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic sclk;
  logic ss_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic blowing;
  wire miso_w;
  logic [3:0] avs_address_i = 4'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [31:0] rd_v;
  logic [175:0] rx;
  logic [127:0] key [3];
  int failures = 0;
  int comparisons = 0;

  // Core clock at 40 MHz
  always #12.5 clk_i = ~clk_i;

  // Undriven serial output floats, so a stale bit cannot pass
  assign miso_w = miso_oe ? miso : 1'bz;

  fkb_boot_port #(.HW_SIG(SIG)) i_fkb_boot_port (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .serial_shift_clock_i(sclk),
    .slave_select_n_i(ss_n),
    .mosi_i(mosi),
    .miso_o(miso),
    .miso_oe_o(miso_oe),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hf),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .blowing_o(blowing)
  );

  fkb_host_model i_fkb_host_model (
    .sclk_o(sclk),
    .ss_n_o(ss_n),
    .mosi_o(mosi),
    .miso_i(miso_w)
  );

  // Verdict and end of run
  task automatic finish_test;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  // Four-state compare
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk

  // Avalon access held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_read_i <= ~wr;
    avs_write_i <= wr;
    avs_address_i <= a;
    avs_writedata_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 100);
    if (n >= 100) begin
      failures++;
      finish_test();
    end
    rd_v = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus

  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd_v, e);
  endtask : rchk

  // Frame with a zero 32-bit data word
  task automatic cmd(input logic [15:0] c);
    i_fkb_host_model.frame(32'h0, c, 128'h0, 32, rx);
  endtask : cmd

  // Bounded wait for the blow engine to finish
  task automatic wait_blow;
    int n;
    n = 0;
    while (blowing === 1'b1 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 3000) begin
      failures++;
      finish_test();
    end
  endtask : wait_blow

  // Main sequence: registers, unlock, three boxes, lock bits
  initial begin
    key[0] = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
    key[1] = 128'h8000_0001_a5a5_5a5a_0f0f_f0f0_c3c3_3c3c;
    key[2] = 128'h0000_0000_0000_0000_0000_0000_0000_0042;
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rchk(4'h0, 32'h10);
    rchk(4'h8, SIG);
    rchk(4'h1, 32'h0);
    bus(1'b1, 4'h0, 32'h8);
    rchk(4'h0, 32'h8);
    bus(1'b1, 4'h0, 32'h20);
    rchk(4'h0, 32'h10);
    cmd(16'h0007);
    bus(1'b0, 4'h4, 32'h0);
    chk(rd_v[3:0], 4'h8);
    bus(1'b1, 4'h4, 32'h8);
    i_fkb_host_model.frame(32'h0, 16'hde05, {32'h5345acba, 96'h0}, 32, rx);
    bus(1'b0, 4'h4, 32'h0);
    chk(rd_v[3:0], 4'h1);
    i_fkb_host_model.frame(32'h0, 16'hde05, {32'hacba5345, 96'h0}, 32, rx);
    bus(1'b0, 4'h4, 32'h0);
    chk(rd_v, {8'h03, 8'h0f, 16'h0002});
    for (int b = 0; b < 3; b++) begin
      i_fkb_host_model.frame(32'h0, 16'h0007, key[b], 128, rx);
      cmd(b == 0 ? 16'h0008 : b == 1 ? 16'h0009 : 16'h000b);
      cmd(16'h000c);
      chk(blowing, 1'b1);
      cmd(16'h0012);
      cmd(16'h0012);
      chk(rx[79:0], {SIG, 16'h0, 32'h1});
      wait_blow();
      cmd(16'h0012);
      cmd(16'h0012);
      chk(rx[79:0], {SIG, 16'h0, 32'h0});
      cmd(b == 0 ? 16'h000d : b == 1 ? 16'h000e : 16'h0010);
      i_fkb_host_model.frame(32'h0, 16'h0011, 128'h0, 128, rx);
      chk(rx[127:0], key[b]);
    end
    rchk(4'hc, 32'h42);
    cmd(16'h000c);
    bus(1'b0, 4'h4, 32'h0);
    chk(rd_v[4:0], 5'h0a);
    bus(1'b1, 4'h4, 32'h8);
    cmd(16'h000d);
    bus(1'b0, 4'h4, 32'h0);
    chk(rd_v[3:0], 4'ha);
    finish_test();
  end
endmodule : tb_fkb_boot_port
